// ### ptf_if.sv
// carrier between the top and the qualifier: config, message, verdict
// assumes: ptf_pkg compiled first
`timescale 1ns/1ps
interface ptf_if;
    import ptf_pkg::*;
    logic [15:0] filter_config;
    logic [15:0] first_byte_filter;
    logic [31:0] user_ip;
    logic [7:0] domain_number_value;
    logic msg_event;
    ptf_transport_t msg_transport;
    logic [31:0] msg_dst_addr;
    logic [7:0] msg_first_byte;
    logic [3:0] msg_version;
    logic [7:0] msg_domain;
    logic msg_alt_master;
    logic [7:0] msg_control;
    logic pass;
    modport owner (
        output filter_config, first_byte_filter, user_ip,
        output domain_number_value, msg_event, msg_transport,
        output msg_dst_addr, msg_first_byte, msg_version, msg_domain,
        output msg_alt_master, msg_control,
        input pass
    );
    modport judge (
        input filter_config, first_byte_filter, user_ip,
        input domain_number_value, msg_event, msg_transport,
        input msg_dst_addr, msg_first_byte, msg_version, msg_domain,
        input msg_alt_master, msg_control,
        output pass
    );
endinterface

// ### ptf_pkg.sv
// constants, field layout and types of the receive timestamp filter
// assumes: included before every other file of the block
//
// Operation
// - domain filter on: domainNumber must equal the programmed value
// - alternate-master suppress on: flagged messages get no timestamp
// - ip half select picks which 16-bit half of user IP is reached
// - custom address filter on: UDP destination equal to user IP qualifies
// - slave-only on: Delay_Req (control field 1) gets no timestamp
// - three multicast bits enable the three standard PTP destination groups
// - layer2 detect on: PTP carried directly in Ethernet is recognised
// - udp6 detect on: PTP carried in UDP over IPv6 is recognised
// - udp4 detect on: PTP carried in UDP over IPv4 is recognised
// - nonzero version filter: only messages of that PTP version qualify
// - version filter zero: version is not checked, any version qualifies
// - receive capture off: no receive timestamps are taken at all
// - first byte compared to match value only where mask bit is one
// - mask all zero: first-byte filter passes every message
// - domain value is bits 7:0 of the extended receive config register
package ptf_pkg;

    // *****************************************************************
    // register indices and byte addresses (4 * index)
    // *****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] IDX_RX_FILTER_CONFIG = 8'h19;
    localparam logic [7:0] IDX_RX_FIRST_BYTE_FILTER = 8'h1a;
    localparam logic [7:0] IDX_IP_ADDRESS_DATA = 8'h1b;
    localparam logic [7:0] IDX_RX_EXTENDED_CONFIG = 8'h1c;
    localparam logic [7:0] IDX_CAPTURE_STATUS = 8'h1f;
    localparam logic [ADDR_W-1:0] ADDR_RX_FILTER_CONFIG =
        ADDR_W'({IDX_RX_FILTER_CONFIG, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_RX_FIRST_BYTE_FILTER =
        ADDR_W'({IDX_RX_FIRST_BYTE_FILTER, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_IP_ADDRESS_DATA =
        ADDR_W'({IDX_IP_ADDRESS_DATA, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_RX_EXTENDED_CONFIG =
        ADDR_W'({IDX_RX_EXTENDED_CONFIG, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_CAPTURE_STATUS =
        ADDR_W'({IDX_CAPTURE_STATUS, 2'b00});

    // *****************************************************************
    // reset values
    // *****************************************************************
    localparam logic [15:0] RST_RX_FILTER_CONFIG = 16'h0000;
    localparam logic [15:0] RST_RX_FIRST_BYTE_FILTER = 16'h0000;
    localparam logic [31:0] RST_USER_IP = 32'h0000_0000;
    localparam logic [7:0] RST_DOMAIN = 8'h00;

    // *****************************************************************
    // field positions of rx_filter_config
    // *****************************************************************
    localparam int BIT_DOMAIN_FILTER_ON = 15;
    localparam int BIT_ALTERNATE_MASTER_SUPPRESS = 14;
    localparam int BIT_IP_HALF_SELECT = 13;
    localparam int BIT_CUSTOM_ADDR_FILTER_ON = 12;
    localparam int BIT_SLAVE_ONLY = 11;
    localparam int LSB_STANDARD_MULTICAST_FILTER = 8;
    localparam int W_STANDARD_MULTICAST_FILTER = 3;
    localparam int BIT_LAYER2_DETECT_ON = 7;
    localparam int BIT_UDP6_DETECT_ON = 6;
    localparam int BIT_UDP4_DETECT_ON = 5;
    localparam int LSB_VERSION_FILTER = 1;
    localparam int W_VERSION_FILTER = 4;
    localparam int BIT_RECEIVE_CAPTURE_ON = 0;

    // rx_first_byte_filter and rx_extended_config fields
    localparam int LSB_FIRST_BYTE_MASK = 8;
    localparam int LSB_FIRST_BYTE_VALUE = 0;
    localparam int LSB_DOMAIN_NUMBER_VALUE = 0;

    // *****************************************************************
    // message constants
    // *****************************************************************
    localparam int CONTROL_FIELD_OFFSET = 32;
    localparam logic [7:0] CONTROL_DELAY_REQ = 8'h01;
    localparam logic [31:0] MC4_PRIMARY = 32'he000_0181;
    localparam logic [31:0] MC4_ALT_FIRST = 32'he000_0182;
    localparam logic [31:0] MC4_ALT_LAST = 32'he000_0184;
    localparam logic [31:0] MC4_PEER_DELAY = 32'he000_006b;
    localparam logic [15:0] MC6_PRIMARY = 16'h0181;
    localparam logic [15:0] MC6_ALT_FIRST = 16'h0182;
    localparam logic [15:0] MC6_ALT_LAST = 16'h0184;
    localparam logic [15:0] MC6_PEER_DELAY = 16'h006b;

    // *****************************************************************
    // axi responses and types
    // *****************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // encoded in declaration order: 0 layer2, 1 udp4, 2 udp6, 3 other
    typedef enum logic [1:0] {
        PTF_TR_LAYER2,
        PTF_TR_UDP4,
        PTF_TR_UDP6,
        PTF_TR_OTHER
    } ptf_transport_t;

endpackage

// ### ptf_properties.sv
// checker on the ports of the receive timestamp filter top
// assumes: bound to ptf_top, single clock aclk, sync reset
`timescale 1ns/1ps
module ptf_properties (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    // message and verdict
    input wire logic msg_valid,
    input wire logic ts_capture,
    input wire logic ts_reject
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ****************************
    // verdict timing
    // ****************************
    one_verdict_a: assert property (
        msg_valid |=> ts_capture ^ ts_reject)
        else $error("verdict missing or doubled");
    no_stray_a: assert property (!msg_valid |=> !ts_capture && !ts_reject)
        else $error("verdict without a message");
    // ****************************
    // bus handshakes
    // ****************************
    b_hold_a: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped");
    b_done_a: assert property (bvalid && bready |=> !bvalid)
        else $error("write response repeated");
    w_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while answer pending");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    r_block_a: assert property (rvalid |-> !arready)
        else $error("read taken while data pending");
    r_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
endmodule
bind ptf_top ptf_properties ptf_properties_inst (.aclk, .aresetn, .awready,
    .wready, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
    .msg_valid, .ts_capture, .ts_reject);

// ### ptf_qualify.sv
// combinational verdict: does the offered message earn a timestamp
// assumes: fields of one parsed message are stable while judged
`timescale 1ns/1ps
module ptf_qualify (
    // carrier
    ptf_if.judge q
);
    import ptf_pkg::*;

    logic [2:0] mc_on;
    logic [3:0] ver_sel;
    logic [7:0] fb_mask;
    logic [7:0] fb_value;
    logic [15:0] low16;
    logic transport_ok;
    logic std4_hit;
    logic std6_hit;
    logic addr_ok;
    logic version_ok;
    logic domain_ok;
    logic alt_ok;
    logic slave_ok;
    logic first_byte_ok;

    always_comb begin
        mc_on = q.filter_config[LSB_STANDARD_MULTICAST_FILTER +:
                                W_STANDARD_MULTICAST_FILTER];
        ver_sel = q.filter_config[LSB_VERSION_FILTER +: W_VERSION_FILTER];
        fb_mask = q.first_byte_filter[LSB_FIRST_BYTE_MASK +: 8];
        fb_value = q.first_byte_filter[LSB_FIRST_BYTE_VALUE +: 8];
        low16 = q.msg_dst_addr[15:0];
        transport_ok = 1'b0;
        unique case (q.msg_transport)
            PTF_TR_LAYER2: transport_ok =
                q.filter_config[BIT_LAYER2_DETECT_ON];
            PTF_TR_UDP4: transport_ok =
                q.filter_config[BIT_UDP4_DETECT_ON];
            PTF_TR_UDP6: transport_ok =
                q.filter_config[BIT_UDP6_DETECT_ON];
            PTF_TR_OTHER: transport_ok = 1'b0;
        endcase
        // ipv6 groups are matched on the group id only, scope ignored
        std4_hit = (mc_on[0] && q.msg_dst_addr == MC4_PRIMARY)
            || (mc_on[1] && q.msg_dst_addr >= MC4_ALT_FIRST
                && q.msg_dst_addr <= MC4_ALT_LAST)
            || (mc_on[2] && q.msg_dst_addr == MC4_PEER_DELAY);
        std6_hit = q.msg_dst_addr[31:16] == 16'h0000
            && ((mc_on[0] && low16 == MC6_PRIMARY)
            || (mc_on[1] && low16 >= MC6_ALT_FIRST
                && low16 <= MC6_ALT_LAST)
            || (mc_on[2] && low16 == MC6_PEER_DELAY));
        addr_ok = (q.msg_transport == PTF_TR_LAYER2)
            || (q.msg_transport == PTF_TR_UDP4 && std4_hit)
            || (q.msg_transport == PTF_TR_UDP6 && std6_hit)
            || (q.filter_config[BIT_CUSTOM_ADDR_FILTER_ON]
                && q.msg_dst_addr == q.user_ip);
        version_ok = (ver_sel == 4'h0)
            || (ver_sel == q.msg_version);
        domain_ok = !q.filter_config[BIT_DOMAIN_FILTER_ON]
            || (q.msg_domain == q.domain_number_value);
        alt_ok = !(q.filter_config[BIT_ALTERNATE_MASTER_SUPPRESS]
            && q.msg_alt_master);
        slave_ok = !q.filter_config[BIT_SLAVE_ONLY]
            || (q.msg_control != CONTROL_DELAY_REQ);
        // a zero mask cancels every bit, so the check passes
        first_byte_ok =
            ((q.msg_first_byte ^ fb_value) & fb_mask) == 8'h00;
        q.pass = q.filter_config[BIT_RECEIVE_CAPTURE_ON]
            && q.msg_event && transport_ok && addr_ok && version_ok
            && domain_ok && alt_ok && slave_ok && first_byte_ok;
    end

endmodule

// ### ptf_top.sv
// receive timestamp filter: axi4-lite registers plus capture decision
// assumes: parsed message fields come from logic on aclk, one message
// per msg_valid pulse, no synchronisers needed
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
module ptf_top #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ptf_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [ptf_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // parsed receive message
    input wire logic msg_valid,
    input wire logic msg_event,
    input wire ptf_pkg::ptf_transport_t msg_transport,
    input wire logic [31:0] msg_dst_addr,
    input wire logic [7:0] msg_first_byte,
    input wire logic [3:0] msg_version,
    input wire logic [7:0] msg_domain,
    input wire logic msg_alt_master,
    input wire logic [7:0] msg_control,
    // decision
    output logic ts_capture,
    output logic ts_reject
);
    import ptf_pkg::*;

    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
        $error("ptf_top: CNT_W must lie in 1..32");
    end

    // *****************************************************************
    // state
    // *****************************************************************
    logic [15:0] filter_config;
    logic [15:0] first_byte_filter;
    logic [31:0] user_ip;
    logic [7:0] domain_number_value;
    logic [CNT_W-1:0] capture_count;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    logic [15:0] next_filter_config;
    logic [15:0] next_first_byte_filter;
    logic [31:0] next_user_ip;
    logic [7:0] next_domain_number_value;
    logic [CNT_W-1:0] next_capture_count;
    logic next_aw_held;
    logic next_w_held;
    logic [ADDR_W-1:0] next_wr_addr;
    logic [31:0] next_wr_data;
    logic [3:0] next_wr_strb;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_ts_capture;
    logic next_ts_reject;

    logic aw_take;
    logic w_take;
    logic do_write;
    logic ar_take;
    logic [15:0] wmask;
    logic [15:0] wval;
    logic [15:0] ip_half;

    // *****************************************************************
    // qualifier
    // *****************************************************************
    ptf_if judge_bus ();

    assign judge_bus.filter_config = filter_config;
    assign judge_bus.first_byte_filter = first_byte_filter;
    assign judge_bus.user_ip = user_ip;
    assign judge_bus.domain_number_value = domain_number_value;
    assign judge_bus.msg_event = msg_event;
    assign judge_bus.msg_transport = msg_transport;
    assign judge_bus.msg_dst_addr = msg_dst_addr;
    assign judge_bus.msg_first_byte = msg_first_byte;
    assign judge_bus.msg_version = msg_version;
    assign judge_bus.msg_domain = msg_domain;
    assign judge_bus.msg_alt_master = msg_alt_master;
    assign judge_bus.msg_control = msg_control;

    ptf_qualify u_qualify (
        .q(judge_bus.judge)
    );

    // *****************************************************************
    // write channel handshake
    // *****************************************************************
    always_comb begin
        aw_take = awvalid && awready;
        w_take = wvalid && wready;
        next_aw_held = aw_held || aw_take;
        next_w_held = w_held || w_take;
        next_wr_addr = aw_take ? awaddr : wr_addr;
        next_wr_data = w_take ? wdata : wr_data;
        next_wr_strb = w_take ? wstrb : wr_strb;
        // commit once both halves are in and no response is pending
        do_write = next_aw_held && next_w_held && !bvalid;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_SLVERR;
            unique case (next_wr_addr[ADDR_W-1:2])
                ADDR_RX_FILTER_CONFIG[ADDR_W-1:2],
                ADDR_RX_FIRST_BYTE_FILTER[ADDR_W-1:2],
                ADDR_IP_ADDRESS_DATA[ADDR_W-1:2],
                ADDR_RX_EXTENDED_CONFIG[ADDR_W-1:2],
                ADDR_CAPTURE_STATUS[ADDR_W-1:2]: next_bresp = RESP_OKAY;
                default: next_bresp = RESP_SLVERR;
            endcase
        end
        // one write in flight: stall both channels until the answer
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
    end

    // *****************************************************************
    // configuration registers
    // *****************************************************************
    always_comb begin
        wmask = {{8{next_wr_strb[1]}}, {8{next_wr_strb[0]}}};
        wval = next_wr_data[15:0];
        next_filter_config = filter_config;
        next_first_byte_filter = first_byte_filter;
        next_user_ip = user_ip;
        next_domain_number_value = domain_number_value;
        if (do_write) begin
            unique case (next_wr_addr[ADDR_W-1:2])
                ADDR_RX_FILTER_CONFIG[ADDR_W-1:2]: begin
                    next_filter_config =
                        (filter_config & ~wmask) | (wval & wmask);
                end
                ADDR_RX_FIRST_BYTE_FILTER[ADDR_W-1:2]: begin
                    next_first_byte_filter =
                        (first_byte_filter & ~wmask) | (wval & wmask);
                end
                ADDR_IP_ADDRESS_DATA[ADDR_W-1:2]: begin
                    // half chosen by the current select bit
                    if (filter_config[BIT_IP_HALF_SELECT]) begin
                        next_user_ip[15:0] =
                            (user_ip[15:0] & ~wmask) | (wval & wmask);
                    end else begin
                        next_user_ip[31:16] =
                            (user_ip[31:16] & ~wmask) | (wval & wmask);
                    end
                end
                ADDR_RX_EXTENDED_CONFIG[ADDR_W-1:2]: begin
                    if (next_wr_strb[0]) begin
                        next_domain_number_value =
                            wval[LSB_DOMAIN_NUMBER_VALUE +: 8];
                    end
                end
                default: begin
                    next_filter_config = filter_config;
                end
            endcase
        end
    end

    // *****************************************************************
    // read channel
    // *****************************************************************
    always_comb begin
        ar_take = arvalid && arready;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        ip_half = filter_config[BIT_IP_HALF_SELECT] ?
            user_ip[15:0] : user_ip[31:16];
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (ar_take) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h0000_0000;
            unique case (araddr[ADDR_W-1:2])
                ADDR_RX_FILTER_CONFIG[ADDR_W-1:2]:
                    next_rdata = {16'h0000, filter_config};
                ADDR_RX_FIRST_BYTE_FILTER[ADDR_W-1:2]:
                    next_rdata = {16'h0000, first_byte_filter};
                ADDR_IP_ADDRESS_DATA[ADDR_W-1:2]:
                    next_rdata = {16'h0000, ip_half};
                ADDR_RX_EXTENDED_CONFIG[ADDR_W-1:2]:
                    next_rdata = {24'h00_0000, domain_number_value};
                ADDR_CAPTURE_STATUS[ADDR_W-1:2]:
                    next_rdata = 32'(capture_count);
                default: next_rresp = RESP_SLVERR;
            endcase
        end
        next_arready = !next_rvalid;
    end

    // *****************************************************************
    // capture decision
    // *****************************************************************
    always_comb begin
        next_ts_capture = msg_valid && judge_bus.pass;
        next_ts_reject = msg_valid && !judge_bus.pass;
        next_capture_count = capture_count;
        // counter is a hint for software, cleared by a write to it, wraps silently
        if (next_ts_capture) begin
            next_capture_count = capture_count + CNT_W'(1);
        end
        if (do_write && next_wr_addr[ADDR_W-1:2]
                == ADDR_CAPTURE_STATUS[ADDR_W-1:2]) begin
            // any write clears; a capture in the same cycle still counts
            next_capture_count = next_ts_capture ? CNT_W'(1) : '0;
        end
    end

    // *****************************************************************
    // registers
    // *****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filter_config <= RST_RX_FILTER_CONFIG;
            first_byte_filter <= RST_RX_FIRST_BYTE_FILTER;
            user_ip <= RST_USER_IP;
            domain_number_value <= RST_DOMAIN;
            capture_count <= '0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= '0;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
            ts_capture <= 1'b0;
            ts_reject <= 1'b0;
        end else begin
            filter_config <= next_filter_config;
            first_byte_filter <= next_first_byte_filter;
            user_ip <= next_user_ip;
            domain_number_value <= next_domain_number_value;
            capture_count <= next_capture_count;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            ts_capture <= next_ts_capture;
            ts_reject <= next_ts_reject;
        end
    end

endmodule

// ### test_ptf_top.sv
// self-checking bench for the receive timestamp filter
// assumes: ptf_pkg, ptf_if, ptf_qualify, ptf_top compiled first
`timescale 1ns/1ps
module test_ptf_top;
    import ptf_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr, msg_first_byte, msg_domain, msg_control;
    logic [31:0] wdata, rdata, msg_dst_addr;
    logic [1:0] bresp, rresp;
    logic msg_valid, msg_event, msg_alt_master, ts_capture, ts_reject;
    logic [3:0] msg_version;
    ptf_transport_t msg_transport;
    localparam ptf_transport_t L2 = PTF_TR_LAYER2;
    logic [31:0] mc4 [3];
    int err_count, n_checks, i;
    ptf_top ptf_top_inst (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
        .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .msg_valid, .msg_event, .msg_transport,
        .msg_dst_addr, .msg_first_byte, .msg_version, .msg_domain,
        .msg_alt_master, .msg_control, .ts_capture, .ts_reject);
    // ****************************
    // tasks
    // ****************************
    task automatic end_sim;
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // handshakes judged at the falling edge, where nothing moves
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        int k;
        logic at, wt, bv;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(negedge aclk);
            at = awvalid && awready;
            wt = wvalid && wready;
            bv = bvalid;
            if (bv && bready) chk(32'(bresp), 32'(RESP_OKAY));
            @(posedge aclk);
            if (at) awvalid <= 1'b0;
            if (wt) wvalid <= 1'b0;
            if (bv && bready) break;
            bready <= bv;
        end
        bready <= 1'b0;
        if (k == 40) begin
            err_count++;
            end_sim();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        int k;
        logic at, rv;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(negedge aclk);
            at = arvalid && arready;
            rv = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (at) arvalid <= 1'b0;
            if (rv && rready) break;
            rready <= rv;
        end
        rready <= 1'b0;
        if (k == 40) begin
            err_count++;
            end_sim();
        end
        chk(d, e);
        chk(32'(r), 32'(er));
    endtask
    // called at a rising edge; verdict seen one cycle later
    task automatic m(input ptf_transport_t t, input logic [31:0] a,
        input logic c);
        msg_valid <= 1'b1;
        msg_transport <= t;
        msg_dst_addr <= a;
        @(posedge aclk);
        msg_valid <= 1'b0;
        @(negedge aclk);
        chk(32'({ts_capture, ts_reject}), 32'({c, !c}));
        @(posedge aclk);
    endtask
    // ****************************
    // sequence
    // ****************************
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, msg_valid} = '0;
        {awaddr, araddr, wdata, msg_dst_addr} = '0;
        {msg_first_byte, msg_domain, msg_control, msg_alt_master} = '0;
        msg_event = 1'b1;
        msg_version = 4'h2;
        msg_transport = PTF_TR_LAYER2;
        mc4 = '{MC4_PRIMARY, 32'he000_0183, MC4_PEER_DELAY};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_RX_FILTER_CONFIG, 32'h0, RESP_OKAY);
        rd(ADDR_RX_FIRST_BYTE_FILTER, 32'h0, RESP_OKAY);
        rd(8'h00, 32'h0, RESP_SLVERR);
        wr(ADDR_RX_FILTER_CONFIG, 16'h0084);
        m(L2, '0, 1'b0);
        wr(ADDR_RX_FILTER_CONFIG, 16'h0085);
        m(L2, '0, 1'b1);
        m(PTF_TR_UDP4, MC4_PRIMARY, 1'b0);
        msg_version <= 4'h3;
        m(L2, '0, 1'b0);
        wr(ADDR_RX_FILTER_CONFIG, 16'h0081);
        msg_alt_master <= 1'b1;
        msg_control <= CONTROL_DELAY_REQ;
        m(L2, '0, 1'b1);
        wr(ADDR_RX_EXTENDED_CONFIG, 16'h0005);
        rd(ADDR_RX_EXTENDED_CONFIG, 32'h5, RESP_OKAY);
        wr(ADDR_RX_FILTER_CONFIG, 16'hc881);
        {msg_domain, msg_control} <= 16'h0502;
        m(L2, '0, 1'b0);
        msg_alt_master <= 1'b0;
        msg_control <= CONTROL_DELAY_REQ;
        m(L2, '0, 1'b0);
        {msg_domain, msg_control} <= 16'h0402;
        m(L2, '0, 1'b0);
        msg_domain <= 8'h05;
        m(L2, '0, 1'b1);
        wr(ADDR_RX_FIRST_BYTE_FILTER, 16'hf0a0);
        msg_first_byte <= 8'ha5;
        m(L2, '0, 1'b1);
        msg_first_byte <= 8'hb0;
        m(L2, '0, 1'b0);
        wr(ADDR_RX_FIRST_BYTE_FILTER, 16'h00ff);
        m(L2, '0, 1'b1);
        for (i = 0; i < 3; i++) begin
            wr(ADDR_RX_FILTER_CONFIG, 16'h0061 | (16'h0100 << i));
            m(PTF_TR_UDP4, mc4[i], 1'b1);
            m(PTF_TR_UDP6, {16'h0000, mc4[i][15:0]}, 1'b1);
            m(PTF_TR_UDP4, mc4[(i + 1) % 3], 1'b0);
        end
        wr(ADDR_RX_FILTER_CONFIG, 16'h0121);
        m(PTF_TR_UDP6, 32'h0000_0181, 1'b0);
        wr(ADDR_RX_FILTER_CONFIG, 16'h1021);
        wr(ADDR_IP_ADDRESS_DATA, 16'hc0a8);
        wr(ADDR_RX_FILTER_CONFIG, 16'h3021);
        wr(ADDR_IP_ADDRESS_DATA, 16'h0101);
        rd(ADDR_IP_ADDRESS_DATA, 32'h0101, RESP_OKAY);
        m(PTF_TR_UDP4, 32'hc0a8_0101, 1'b1);
        m(PTF_TR_UDP4, 32'hc0a8_0102, 1'b0);
        m(PTF_TR_OTHER, 32'hc0a8_0101, 1'b0);
        wr(ADDR_RX_FILTER_CONFIG, 16'h1021);
        rd(ADDR_RX_FILTER_CONFIG, 32'h1021, RESP_OKAY);
        rd(ADDR_IP_ADDRESS_DATA, 32'hc0a8, RESP_OKAY);
        msg_event <= 1'b0;
        m(PTF_TR_UDP4, 32'hc0a8_0101, 1'b0);
        rd(ADDR_CAPTURE_STATUS, 32'hc, RESP_OKAY);
        end_sim();
    end
endmodule
